// ---- hw/xmp_pkg.sv ----
// constants and types for the external data space address map and port
package xmp_pkg;
  // ---------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;

  // ---------------------------------------------------------------
  // register reset values and config write mask
  // ---------------------------------------------------------------
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h03;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h5F;

  // ---------------------------------------------------------------
  // ext_mem_config_reg fields
  // ---------------------------------------------------------------
  localparam int CFG_OVERLAY_BIT = 6;
  localparam int CFG_NONMUX_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_ALE_LSB = 0;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [15:0] FIFO_BASE = 16'h0400;
  localparam logic [15:0] FIFO_LAST = 16'h07FF;
  localparam logic [15:0] RAM_LAST_4K = 16'h0FFF;
  localparam logic [15:0] RAM_LAST_2K = 16'h07FF;
  localparam int RAM_WORDS = 4096;

  // ---------------------------------------------------------------
  // off-chip bus and fifo access timing
  // ---------------------------------------------------------------
  localparam int EXT_ADDR_NS = 10;
  localparam int EXT_STROBE_NS = 20;
  localparam int EXT_HOLD_NS = 5;
  localparam int FIFO_MIN_NS = 10;
  localparam logic [3:0] EXT_ADDR_CYC = 4'((EXT_ADDR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] EXT_STROBE_CYC =
    4'((EXT_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] EXT_HOLD_CYC = 4'((EXT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] FIFO_MIN_CYC = 4'((FIFO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    XMP_MODE_ONCHIP = 2'b00,
    XMP_MODE_SPLIT_NOBANK = 2'b01,
    XMP_MODE_SPLIT_BANK = 2'b10,
    XMP_MODE_OFFCHIP = 2'b11
  } xmp_mode_t;

  typedef enum logic [1:0] {
    XMP_TGT_RAM = 2'b00,
    XMP_TGT_FIFO = 2'b01,
    XMP_TGT_EXT = 2'b10
  } xmp_tgt_t;

  typedef enum logic [2:0] {
    XMP_ST_IDLE = 3'b000,
    XMP_ST_RAM = 3'b001,
    XMP_ST_FIFO = 3'b010,
    XMP_ST_ADDR = 3'b011,
    XMP_ST_STROBE = 3'b100,
    XMP_ST_HOLD = 3'b101
  } xmp_state_t;
endpackage : xmp_pkg

// ---- hw/xmp_decode.sv ----
// target decode for one external data space address
`timescale 1ns/100ps
`default_nettype none
module xmp_decode (
  input wire logic [15:0] addr,
  input wire logic [1:0] mode,
  input wire logic usb_fifo_overlay_enable,
  input wire logic indexed,
  input wire logic ram_4k,
  output var xmp_pkg::xmp_tgt_t target,
  output logic [11:0] ram_idx,
  output logic hi_drv
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic in_fifo;
  logic below_ram;

  always_comb begin
    in_fifo = usb_fifo_overlay_enable && (addr >= xmp_pkg::FIFO_BASE)
      && (addr <= xmp_pkg::FIFO_LAST);
    below_ram = ram_4k ? (addr <= xmp_pkg::RAM_LAST_4K) : (addr <= xmp_pkg::RAM_LAST_2K);
    ram_idx = ram_4k ? addr[11:0] : {1'b0, addr[10:0]};
    hi_drv = !((mode == xmp_pkg::XMP_MODE_SPLIT_NOBANK) && indexed);
    case (mode)
      xmp_pkg::XMP_MODE_ONCHIP: target = xmp_pkg::XMP_TGT_RAM;
      xmp_pkg::XMP_MODE_SPLIT_NOBANK,
      xmp_pkg::XMP_MODE_SPLIT_BANK: begin
        target = below_ram ? xmp_pkg::XMP_TGT_RAM : xmp_pkg::XMP_TGT_EXT;
      end
      xmp_pkg::XMP_MODE_OFFCHIP: target = xmp_pkg::XMP_TGT_EXT;
      default: target = xmp_pkg::XMP_TGT_RAM;
    endcase
    if (in_fifo) begin
      target = xmp_pkg::XMP_TGT_FIFO;
    end
  end
endmodule : xmp_decode
`default_nettype wire

// ---- hw/xmp_top.sv ----
// external data space address map, on-chip ram and off-chip memory port
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - a move goes to the data space unless the other target input is set
// - on-chip ram, 4k or 2k by variant, lives in the data space
// - pointer form uses all 16 bits of the data pointer as address
// - data pointer high and low bytes are written and read separately
// - indexed form takes high byte from page select, low from index 0 or 1
// - overlay enable maps usb fifo ram at 0x0400 to 0x07FF
// - while overlaid, normal ram in that range is reached only through its aliased addresses in on-chip mode
// - fifo moves take more cycles than ordinary ram moves
// - four memory modes decide where each move is directed
// - off-chip address, data and control appear on the port pins
// - pins are claimed only during an off-chip move
// - pins acting as inputs have their drivers off during the move
// - open-drain or push-pull choice is left to the port logic
// - overlay enable is bit 6 of the configuration register
module xmp_top #(
  parameter bit RAM_4K = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_wdata,
  input wire logic ptr_hi_we,
  input wire logic ptr_lo_we,
  input wire logic page_we,
  input wire logic cfg_we,
  output logic [7:0] data_pointer_high_byte,
  output logic [7:0] data_pointer_low_byte,
  output logic [7:0] external_data_space_page_select_reg,
  output logic [7:0] ext_mem_config_reg,
  input wire logic move_req,
  input wire logic move_indexed,
  input wire logic move_index_sel,
  input wire logic [7:0] index_reg_zero,
  input wire logic [7:0] index_reg_one,
  input wire logic move_we,
  input wire logic [7:0] move_wdata,
  input wire logic other_target,
  output logic move_busy,
  output logic move_done,
  output logic [7:0] move_rdata,
  output logic fifo_req,
  output logic [9:0] fifo_addr,
  output logic fifo_we,
  output logic [7:0] fifo_wdata,
  input wire logic fifo_ack,
  input wire logic [7:0] fifo_rdata,
  output logic [7:0] ext_addr_hi,
  output logic ext_addr_hi_oe,
  output logic [7:0] ext_addr_lo,
  output logic ext_addr_lo_oe,
  output logic [7:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic [7:0] ext_data_in,
  output logic ext_rd_b,
  output logic ext_wr_b,
  output logic ext_ale,
  output logic ext_ctrl_oe
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    xmp_pkg::xmp_state_t st;
    logic [15:0] data_pointer_reg;
    logic [7:0] page;
    logic [7:0] cfg;
    logic [3:0] cnt;
    logic [15:0] addr;
    logic [11:0] ram_idx;
    logic we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
    logic hi_drv;
    logic mux;
  } xmp_regs_t;

  xmp_regs_t q;
  xmp_regs_t next_q;
  logic [7:0] ram [xmp_pkg::RAM_WORDS];
  logic [15:0] req_addr;
  logic [7:0] req_index;
  logic start;
  logic ext_busy;
  xmp_pkg::xmp_tgt_t req_tgt;
  logic [11:0] req_ram_idx;
  logic req_hi_drv;

  // ---------------------------------------------------------------
  // address forming and decode
  // ---------------------------------------------------------------
  always_comb begin
    req_index = move_index_sel ? index_reg_one : index_reg_zero;
    req_addr = move_indexed ? {q.page, req_index} : q.data_pointer_reg;
    start = move_req && !other_target && (q.st == xmp_pkg::XMP_ST_IDLE);
  end

  xmp_decode i_xmp_decode (
    .addr(req_addr),
    .mode(q.cfg[xmp_pkg::CFG_MODE_LSB +: 2]),
    .usb_fifo_overlay_enable(q.cfg[xmp_pkg::CFG_OVERLAY_BIT]),
    .indexed(move_indexed),
    .ram_4k(RAM_4K),
    .target(req_tgt),
    .ram_idx(req_ram_idx),
    .hi_drv(req_hi_drv)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (ptr_hi_we) begin
      next_q.data_pointer_reg[15:8] = reg_wdata;
    end
    if (ptr_lo_we) begin
      next_q.data_pointer_reg[7:0] = reg_wdata;
    end
    if (page_we) begin
      next_q.page = reg_wdata;
    end
    if (cfg_we) begin
      next_q.cfg = reg_wdata & xmp_pkg::CFG_WRITE_MASK;
    end
    case (q.st)
      xmp_pkg::XMP_ST_IDLE: begin
        if (start) begin
          next_q.addr = req_addr;
          next_q.ram_idx = req_ram_idx;
          next_q.we = move_we;
          next_q.wdata = move_wdata;
          next_q.hi_drv = req_hi_drv;
          next_q.mux = !q.cfg[xmp_pkg::CFG_NONMUX_BIT];
          case (req_tgt)
            xmp_pkg::XMP_TGT_RAM: next_q.st = xmp_pkg::XMP_ST_RAM;
            xmp_pkg::XMP_TGT_FIFO: begin
              next_q.st = xmp_pkg::XMP_ST_FIFO;
              next_q.cnt = xmp_pkg::FIFO_MIN_CYC;
            end
            default: begin
              next_q.st = xmp_pkg::XMP_ST_ADDR;
              next_q.cnt = xmp_pkg::EXT_ADDR_CYC
                + {2'b00, q.cfg[xmp_pkg::CFG_ALE_LSB +: 2]};
            end
          endcase
        end
      end
      xmp_pkg::XMP_ST_RAM: begin
        next_q.rdata = ram[q.ram_idx];
        next_q.done = 1'b1;
        next_q.st = xmp_pkg::XMP_ST_IDLE;
      end
      xmp_pkg::XMP_ST_FIFO: begin
        if (q.cnt != 4'h0) begin
          next_q.cnt = q.cnt - 4'h1;
        end else if (fifo_ack) begin
          next_q.rdata = fifo_rdata;
          next_q.done = 1'b1;
          next_q.st = xmp_pkg::XMP_ST_IDLE;
        end
      end
      xmp_pkg::XMP_ST_ADDR: begin
        if (q.cnt > 4'h1) begin
          next_q.cnt = q.cnt - 4'h1;
        end else begin
          next_q.cnt = xmp_pkg::EXT_STROBE_CYC;
          next_q.st = xmp_pkg::XMP_ST_STROBE;
        end
      end
      xmp_pkg::XMP_ST_STROBE: begin
        if (q.cnt > 4'h1) begin
          next_q.cnt = q.cnt - 4'h1;
        end else begin
          if (!q.we) begin
            next_q.rdata = ext_data_in;
          end
          next_q.cnt = xmp_pkg::EXT_HOLD_CYC;
          next_q.st = xmp_pkg::XMP_ST_HOLD;
        end
      end
      xmp_pkg::XMP_ST_HOLD: begin
        if (q.cnt > 4'h1) begin
          next_q.cnt = q.cnt - 4'h1;
        end else begin
          next_q.done = 1'b1;
          next_q.st = xmp_pkg::XMP_ST_IDLE;
        end
      end
      default: next_q.st = xmp_pkg::XMP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{st: xmp_pkg::XMP_ST_IDLE, data_pointer_reg: xmp_pkg::PTR_RESET,
             page: xmp_pkg::PAGE_RESET, cfg: xmp_pkg::CFG_RESET,
             cnt: 4'h0, addr: 16'h0000, ram_idx: 12'h000, we: 1'b0,
             wdata: 8'h00, rdata: 8'h00, done: 1'b0, hi_drv: 1'b0, mux: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // on-chip ram
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if ((q.st == xmp_pkg::XMP_ST_RAM) && q.we) begin
      ram[q.ram_idx] <= q.wdata;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    ext_busy = (q.st == xmp_pkg::XMP_ST_ADDR) || (q.st == xmp_pkg::XMP_ST_STROBE)
      || (q.st == xmp_pkg::XMP_ST_HOLD);
    data_pointer_high_byte = q.data_pointer_reg[15:8];
    data_pointer_low_byte = q.data_pointer_reg[7:0];
    external_data_space_page_select_reg = q.page;
    ext_mem_config_reg = q.cfg;
    move_busy = (q.st != xmp_pkg::XMP_ST_IDLE);
    move_done = q.done;
    move_rdata = q.rdata;
    fifo_req = (q.st == xmp_pkg::XMP_ST_FIFO);
    fifo_addr = q.addr[9:0];
    fifo_we = q.we;
    fifo_wdata = q.wdata;
    // pin drive mode is left to the port logic
    ext_addr_hi = q.addr[15:8];
    ext_addr_hi_oe = ext_busy && q.hi_drv;
    ext_addr_lo = q.addr[7:0];
    ext_addr_lo_oe = ext_busy && !q.mux;
    ext_data_out = (q.mux && (q.st == xmp_pkg::XMP_ST_ADDR)) ? q.addr[7:0] : q.wdata;
    ext_data_oe = ext_busy && (q.we || (q.mux && (q.st == xmp_pkg::XMP_ST_ADDR)));
    ext_rd_b = !((q.st == xmp_pkg::XMP_ST_STROBE) && !q.we);
    ext_wr_b = !((q.st == xmp_pkg::XMP_ST_STROBE) && q.we);
    ext_ale = q.mux && (q.st == xmp_pkg::XMP_ST_ADDR);
    ext_ctrl_oe = ext_busy;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_ptr_addr;
    @(posedge clk) disable iff (!rst_b)
      (start && !move_indexed) |=> (q.addr == $past(q.data_pointer_reg));
  endproperty
  a_ptr_addr: assert property (p_ptr_addr) else $error("pointer address wrong");

  property p_idx_addr;
    @(posedge clk) disable iff (!rst_b)
      (start && move_indexed && !move_index_sel)
        |=> (q.addr == {$past(q.page), $past(index_reg_zero)});
  endproperty
  a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");

  property p_hi_write;
    @(posedge clk) disable iff (!rst_b)
      (ptr_hi_we && !ptr_lo_we) |=> (data_pointer_high_byte == $past(reg_wdata))
        && $stable(data_pointer_low_byte);
  endproperty
  a_hi_write: assert property (p_hi_write) else $error("pointer high byte wrong");

  property p_fifo_map;
    @(posedge clk) disable iff (!rst_b)
      (start && q.cfg[xmp_pkg::CFG_OVERLAY_BIT] && (req_addr[15:10] == 6'h01)) |=> fifo_req;
  endproperty
  a_fifo_map: assert property (p_fifo_map) else $error("fifo window missed");

  property p_fifo_slow;
    @(posedge clk) disable iff (!rst_b)
      $rose(fifo_req) |-> !move_done [*3];
  endproperty
  a_fifo_slow: assert property (p_fifo_slow) else $error("fifo move too fast");

  property p_ram_fast;
    @(posedge clk) disable iff (!rst_b)
      (q.st == xmp_pkg::XMP_ST_RAM) |=> move_done && !move_busy;
  endproperty
  a_ram_fast: assert property (p_ram_fast) else $error("ram move not done");

  property p_no_claim;
    @(posedge clk) disable iff (!rst_b)
      ((q.st == xmp_pkg::XMP_ST_RAM) || fifo_req || !move_busy)
        |-> !ext_ctrl_oe && !ext_data_oe && !ext_addr_hi_oe && !ext_addr_lo_oe;
  endproperty
  a_no_claim: assert property (p_no_claim) else $error("pins driven off move");

  property p_read_in;
    @(posedge clk) disable iff (!rst_b)
      (!ext_rd_b) |-> !ext_data_oe && ext_ctrl_oe;
  endproperty
  a_read_in: assert property (p_read_in) else $error("data driven in read");

  property p_mode_off;
    @(posedge clk) disable iff (!rst_b)
      (start && (q.cfg[xmp_pkg::CFG_MODE_LSB +: 2] == xmp_pkg::XMP_MODE_OFFCHIP)
        && !q.cfg[xmp_pkg::CFG_OVERLAY_BIT]) |=> ext_ctrl_oe;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("off-chip mode missed");

  property p_cfg_bit;
    @(posedge clk) disable iff (!rst_b)
      cfg_we |=> (ext_mem_config_reg[xmp_pkg::CFG_OVERLAY_BIT]
        == $past(reg_wdata[xmp_pkg::CFG_OVERLAY_BIT])) && !ext_mem_config_reg[7];
  endproperty
  a_cfg_bit: assert property (p_cfg_bit) else $error("overlay bit wrong");
endmodule : xmp_top
`default_nettype wire

// ---- dv/xmp_ext_mem.sv ----
// off-chip byte memory on the external port pins
`timescale 1ns/100ps
`default_nettype none
module xmp_ext_mem (
  input wire logic clk,
  input wire logic [7:0] ext_addr_hi,
  input wire logic [7:0] ext_addr_lo,
  input wire logic ext_addr_lo_oe,
  input wire logic [7:0] ext_data_out,
  input wire logic ext_data_oe,
  input wire logic ext_rd_b,
  input wire logic ext_wr_b,
  input wire logic ext_ale,
  input wire logic ext_ctrl_oe,
  output logic [7:0] ext_data_in
);
  // ---------------------------------------------------------------
  // storage and address latch
  // ---------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [7:0] lo_q = 8'h00;
  logic [7:0] last = 8'h00;
  logic [15:0] addr;
  logic rd_on;
  assign addr = {ext_addr_hi, lo_q};
  assign rd_on = ext_ctrl_oe && !ext_rd_b;
  always @(posedge clk) begin
    if (ext_ale) begin
      lo_q <= ext_data_out;
    end else if (ext_addr_lo_oe) begin
      lo_q <= ext_addr_lo;
    end
    if (ext_ctrl_oe && !ext_wr_b && ext_data_oe) begin // strobes count only while claimed
      mem[addr] <= ext_data_out;
    end
    if (rd_on) begin
      last <= mem[addr];
    end
  end
  // released bus shows the inverse of the last byte
  assign ext_data_in = rd_on ? mem[addr] : ~last;
endmodule : xmp_ext_mem
`default_nettype wire

// ---- dv/xmp_top_test.sv ----
// self-checking testbench for the data space map and off-chip port
`timescale 1ns/100ps
`default_nettype none
module xmp_top_test;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk, rst_b, ptr_hi_we, ptr_lo_we, page_we, cfg_we;
  logic [7:0] reg_wdata, data_pointer_high_byte, data_pointer_low_byte;
  logic [7:0] external_data_space_page_select_reg, ext_mem_config_reg;
  logic move_req, move_indexed, move_index_sel, move_we, other_target;
  logic [7:0] index_reg_zero, index_reg_one, move_wdata, move_rdata;
  logic move_busy, move_done, fifo_req, fifo_we;
  logic fifo_ack = 1'b0;
  logic [7:0] fifo_rdata = 8'h00;
  logic [9:0] fifo_addr;
  logic [7:0] fifo_wdata, ext_addr_hi, ext_addr_lo, ext_data_out, ext_data_in;
  logic ext_addr_hi_oe, ext_addr_lo_oe, ext_data_oe, ext_rd_b, ext_wr_b;
  logic ext_ale, ext_ctrl_oe;
  logic [7:0] fifo_mem [0:1023];
  logic oe_seen = 1'b0;
  logic rd_clash = 1'b0;
  logic [7:0] hi_seen = 8'h00;
  logic [9:0] fifo_addr_seen = 10'h000;
  logic [7:0] rd;
  int n;
  int num_errors = 0;
  int num_checks = 0;

  xmp_top i_xmp_top (.clk, .rst_b, .reg_wdata, .ptr_hi_we, .ptr_lo_we, .page_we,
    .cfg_we, .data_pointer_high_byte, .data_pointer_low_byte, .external_data_space_page_select_reg,
    .ext_mem_config_reg, .move_req, .move_indexed, .move_index_sel, .index_reg_zero,
    .index_reg_one, .move_we, .move_wdata, .other_target, .move_busy, .move_done,
    .move_rdata, .fifo_req, .fifo_addr, .fifo_we, .fifo_wdata, .fifo_ack, .fifo_rdata,
    .ext_addr_hi, .ext_addr_hi_oe, .ext_addr_lo, .ext_addr_lo_oe, .ext_data_out,
    .ext_data_oe, .ext_data_in, .ext_rd_b, .ext_wr_b, .ext_ale, .ext_ctrl_oe);

  xmp_ext_mem i_xmp_ext_mem (.clk, .ext_addr_hi, .ext_addr_lo, .ext_addr_lo_oe,
    .ext_data_out, .ext_data_oe, .ext_rd_b, .ext_wr_b, .ext_ale, .ext_ctrl_oe,
    .ext_data_in);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // pin monitor and fifo side
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (ext_addr_hi_oe || ext_addr_lo_oe || ext_data_oe || ext_ctrl_oe) begin
      oe_seen <= 1'b1;
    end
    if (ext_ctrl_oe && !ext_rd_b && ext_data_oe) begin
      rd_clash <= 1'b1;
    end
    if (ext_addr_hi_oe) begin
      hi_seen <= ext_addr_hi;
    end
    if (fifo_req) begin
      fifo_addr_seen <= fifo_addr;
    end
  end

  // usb side kept running during every fifo access
  always @(negedge clk) begin
    fifo_ack <= fifo_req;
    fifo_rdata <= fifo_mem[fifo_addr];
    if (fifo_req && fifo_we) begin
      fifo_mem[fifo_addr] <= fifo_wdata;
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: %s is %h, want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wreg(input int which, input logic [7:0] v);
    reg_wdata = v;
    ptr_hi_we = (which == 0);
    ptr_lo_we = (which == 1);
    page_we = (which == 2);
    cfg_we = (which == 3);
    @(negedge clk);
    {ptr_hi_we, ptr_lo_we, page_we, cfg_we} = 4'h0;
  endtask : wreg

  task automatic set_ptr(input logic [15:0] a);
    wreg(0, a[15:8]);
    wreg(1, a[7:0]);
  endtask : set_ptr

  task automatic move(input logic ix, input logic we, input logic [7:0] wd);
    move_indexed = ix;
    move_we = we;
    move_wdata = wd;
    move_req = 1'b1;
    oe_seen = 1'b0;
    rd_clash = 1'b0;
    @(negedge clk);
    move_req = 1'b0;
    n = 1;
    while (move_done !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      num_errors++;
      close_out();
    end else begin
      rd = move_rdata;
      @(negedge clk);
      check({ext_addr_hi_oe, ext_addr_lo_oe, ext_data_oe, ext_ctrl_oe}, 16'h0000, "pins");
    end
  endtask : move

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {ptr_hi_we, ptr_lo_we, page_we, cfg_we, move_req, move_indexed} = 6'h00;
    {move_index_sel, move_we, other_target} = 3'h0;
    {reg_wdata, index_reg_zero, index_reg_one, move_wdata} = 32'h0000_0000;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    check({data_pointer_high_byte, data_pointer_low_byte}, 16'h0000, "ptr rst");
    check(external_data_space_page_select_reg, 16'h0000, "page rst");
    check(ext_mem_config_reg, 16'h0003, "cfg rst");
    wreg(3, 8'hFF);
    check(ext_mem_config_reg, 16'h005F, "cfg mask");
    wreg(3, 8'h00);
    set_ptr(16'h0123);
    check({data_pointer_high_byte, data_pointer_low_byte}, 16'h0123, "ptr");
    move(1'b0, 1'b1, 8'h5A);
    check(16'(n), 16'h0002, "ram cycles");
    check(oe_seen, 16'h0000, "ram pins");
    set_ptr(16'h1123);
    move(1'b0, 1'b0, 8'h00);
    check(rd, 16'h005A, "alias read");
    wreg(2, 8'h01);
    for (int s = 0; s < 2; s++) begin
      move_index_sel = s[0];
      index_reg_zero = s[0] ? 8'h77 : 8'h23;
      index_reg_one = s[0] ? 8'h23 : 8'h77;
      move(1'b1, 1'b0, 8'h00);
      check(rd, 16'h005A, "indexed read");
    end
    other_target = 1'b1;
    move_req = 1'b1;
    repeat (4) @(negedge clk);
    check(move_busy, 16'h0000, "other target");
    move_req = 1'b0;
    other_target = 1'b0;
    set_ptr(16'h0456);
    move(1'b0, 1'b1, 8'h11);
    wreg(3, 8'h40); // overlay on before fifo moves
    move(1'b0, 1'b1, 8'h3C); // unused fifo byte as storage
    check(fifo_addr_seen, 16'h0056, "fifo addr");
    check(16'(n > 2), 16'h0001, "fifo slower");
    check(oe_seen, 16'h0000, "fifo pins");
    move(1'b0, 1'b0, 8'h00);
    check(rd, 16'h003C, "fifo read");
    wreg(3, 8'h00);
    move(1'b0, 1'b0, 8'h00);
    check(rd, 16'h0011, "ram kept");
    wreg(3, 8'h0C); // mux, then mode, no extra ALE cycles
    set_ptr(16'h2345);
    move(1'b0, 1'b1, 8'hA5);
    check(16'(n), 16'h0008, "ext cycles");
    check(hi_seen, 16'h0023, "ext addr hi");
    move(1'b0, 1'b0, 8'h00);
    check(rd, 16'h00A5, "ext read");
    check(rd_clash, 16'h0000, "data driven");
    wreg(3, 8'h1D);
    move(1'b0, 1'b0, 8'h00);
    check(16'(n), 16'h0009, "nonmux cycles");
    check(rd, 16'h00A5, "nonmux read");
    for (int m = 1; m < 3; m++) begin
      wreg(3, 8'(m << 2));
      set_ptr(16'h0123);
      move(1'b0, 1'b0, 8'h00);
      check({oe_seen, rd}, 16'h005A, "split low");
      set_ptr(16'h2345);
      move(1'b0, 1'b0, 8'h00);
      check({oe_seen, rd}, 16'h01A5, "split high");
    end
    close_out();
  end

  initial begin
    #400000;
    num_errors++;
    close_out();
  end
endmodule : xmp_top_test
`default_nettype wire
